/* verification/sram_dev_model.sv */
`timescale 1ns/1ps
module sram_dev_model import sram_host_pkg::*; #(
  parameter int T_ACC = 15,
  parameter int T_HOLD = 4,
  parameter int T_OFF = 9
) (
  // Pins from the host
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic sel_n,
  input wire logic wen_n,
  // Read data back to the host
  output logic [DATA_W-1:0] rdata_out
);
  // Sparse storage of 4-bit words
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  // Phases decoded from pin levels alone, no clock
  wire rd_act = !sel_n && wen_n;
  wire wr_act = !sel_n && !wen_n;
  initial rdata_out = '0;
  // Access lands only if the read is still open at that address, so a
  // momentary read level while select and write-enable swap leaves no data
  task automatic land(input logic [ADDR_W-1:0] a);
    #(T_ACC);
    if (rd_act && (addr_in == a)) begin
      rdata_out <= mem.exists(a) ? mem[a] : '0;
    end
  endtask
  // Word taken as the write interval closes, whichever pin rises first
  always @(negedge wr_act) begin
    if (!$isunknown(addr_in)) begin
      mem[addr_in] = wdata_in;
    end
  end
  // Output follows select, write enable and address
  always @(rd_act or addr_in) begin
    if (!rd_act) begin
      // Forced low when deselected or writing
      rdata_out <= #(T_OFF) '0;
    end else begin
      // Old word holds, then garbage until the access time
      rdata_out <= #(T_HOLD) ~rdata_out;
      fork
        land(addr_in);
      join_none
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import sram_host_pkg::*;
  // Compare two values and count
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
  // Clock, reset and user side
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [DATA_W-1:0] REQ_WDATA = '0;
  logic REQ_READY, RSP_VALID, SEL_N, WEN_N;
  logic [DATA_W-1:0] RSP_RDATA, WDATA_IN, RDATA_OUT;
  logic [ADDR_W-1:0] ADDR_IN;
  // Bench bookkeeping
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int low_cnt = 0;
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W+DATA_W-1:0] wexp_q [$]; // Address and data of each write, oldest first
  logic [DATA_W-1:0] exp_d; // Oldest read note, taken once per answer
  logic [ADDR_W+DATA_W-1:0] wexp_d; // Oldest write note
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  logic [31:0] seed = 32'h4060;
  logic [ADDR_W-1:0] addr_prev = '0;
  logic sel_prev = 1'b1;
  logic wr_prev = 1'b0;
  logic [ADDR_W-1:0] ra [8];

  sram_host_ctrl i_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .SEL_N(SEL_N), .WEN_N(WEN_N),
    .RDATA_OUT(RDATA_OUT));
  sram_dev_model i_mem (.addr_in(ADDR_IN), .wdata_in(WDATA_IN), .sel_n(SEL_N), .wen_n(WEN_N),
    .rdata_out(RDATA_OUT));

  // Free-running clock
  initial begin
    forever #4 REF_CLK = ~REF_CLK;
  end

  // Next pseudo-random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One request, held until taken; reads note their expected word
  task automatic req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    while (REQ_READY !== 1'b1) begin
      @(posedge REF_CLK);
      #1;
    end
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_ADDR = a;
    REQ_WDATA = d;
    if (wr) begin
      ref_mem[a] = d;
      wexp_q.push_back({a, d});
    end else exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : '0);
    @(posedge REF_CLK);
    #1;
    REQ_VALID = 1'b0;
  endtask

  // Let all answers drain, bounded
  task automatic drain(input string name);
    int n;
    for (n = 0; n < 200 && (exp_q.size() != 0 || REQ_READY !== 1'b1); n++) @(posedge REF_CLK);
    `CHK(exp_q.size(), 0)
    `CHK(wexp_q.size(), 0)
    $display("Test %s done", name);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Answer and pin watcher, sampled once updates have landed
  always @(posedge REF_CLK) begin
    #1;
    if (RSP_VALID === 1'b1) begin
      if (exp_q.size() == 0) `CHK(RSP_VALID, 1'b0)
      else begin
        // Pop once, so a mismatch report does not eat the next note
        exp_d = exp_q.pop_front();
        `CHK(RSP_RDATA, exp_d)
      end
    end
    if (!SEL_N && sel_prev) `CHK(ADDR_IN, addr_prev)
    if (!WEN_N) `CHK(SEL_N, 1'b0)
    if (!SEL_N && !WEN_N && wr_prev) `CHK(ADDR_IN, addr_prev)
    if (!SEL_N && !WEN_N) low_cnt++;
    else if (wr_prev) begin
      `CHK(low_cnt, WRITE_LOW_CYC)
      low_cnt = 0;
      // Address and data still stand one cycle past the end of write
      if (wexp_q.size() != 0) wexp_d = wexp_q.pop_front();
      else wexp_d = 'x;
      `CHK({ADDR_IN, WDATA_IN}, wexp_d)
    end
    addr_prev = ADDR_IN;
    sel_prev = SEL_N;
    wr_prev = !SEL_N && !WEN_N;
  end

  // Hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    int i;
    repeat (2) @(posedge REF_CLK);
    #1;
    `CHK({REQ_READY, RSP_VALID, SEL_N, WEN_N, ADDR_IN}, {4'b1011, 20'h00000})
    ARST_N = 1'b1;
    // Boundary addresses, write then read back to back
    req(1'b1, 20'h00000, 4'ha);
    req(1'b1, 20'hfffff, 4'h5);
    req(1'b0, 20'h00000, 4'h0);
    req(1'b0, 20'hfffff, 4'h0);
    req(1'b1, 20'h00000, 4'h3);
    req(1'b0, 20'h00000, 4'h0);
    drain("edges");
    // Random words at random places
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ra[i] = seed[ADDR_W-1:0];
      req(1'b1, ra[i], seed[27:24]);
    end
    for (i = 0; i < 8; i++) req(1'b0, ra[i], seed[3:0]);
    drain("random");
    // Request offered while busy is ignored
    req(1'b1, 20'h12345, 4'h9);
    @(posedge REF_CLK);
    #1;
    REQ_VALID = 1'b1;
    REQ_WRITE = 1'b1;
    REQ_WDATA = 4'h6;
    repeat (2) @(posedge REF_CLK);
    #1;
    REQ_VALID = 1'b0;
    req(1'b0, 20'h12345, 4'h0);
    drain("busy");
    wrap_up();
  end
endmodule

/* verilog/rdata_sync.sv */
`timescale 1ns/1ps
module rdata_sync import sram_host_pkg::*; #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pin level
  input wire logic [W-1:0] pin,
  // Second and third stage
  output logic [W-1:0] stage2,
  output logic [W-1:0] stage3
);

  logic [W-1:0] stage1_reg; // Metastable stage, read only by stage 2
  logic [W-1:0] stage2_reg; // Second stage
  logic [W-1:0] stage3_reg; // Third stage
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_next;
  logic [W-1:0] stage3_next;

  // Shift the pin level along the chain
  always_comb begin
    stage1_next = pin;
    stage2_next = stage1_reg;
    stage3_next = stage2_reg;
  end

  // Register the chain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      stage3_reg <= stage3_next;
    end
  end

  assign stage2 = stage2_reg;
  assign stage3 = stage3_reg;

endmodule

/* verilog/sram_host_ctrl.sv */
`timescale 1ns/1ps
module sram_host_ctrl import sram_host_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Request from user logic
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  output logic REQ_READY,
  // Read answer to user logic
  output logic RSP_VALID,
  output logic [DW-1:0] RSP_RDATA,
  // Memory pins
  output logic [AW-1:0] ADDR_IN,
  output logic [DW-1:0] WDATA_IN,
  output logic SEL_N,
  output logic WEN_N,
  input wire logic [DW-1:0] RDATA_OUT
);

  localparam logic [7:0] ACC_WAIT = 8'(ACCESS_CYC + SYNC_CYC); // Access plus synchroniser
  localparam logic [7:0] WLOW_WAIT = 8'(WRITE_LOW_CYC); // Write strobe low time
  localparam logic [7:0] CNT_MAX = 8'hff; // Saturation of helper counts

  state_t state_reg, state_next; // Sequencer state
  logic [7:0] cnt_reg, cnt_next; // Cycles spent in a timed state
  logic is_wr_reg, is_wr_next; // Current access is a write
  logic [AW-1:0] addr_reg, addr_next; // Address pins
  logic [DW-1:0] wdata_reg, wdata_next; // Write data pins
  logic sel_n_reg, sel_n_next; // Select pin
  logic wen_n_reg, wen_n_next; // Write-enable pin
  logic ready_reg, ready_next; // Request port free
  logic rsp_v_reg, rsp_v_next; // Answer strobe
  logic [DW-1:0] rsp_d_reg, rsp_d_next; // Answer data
  logic [DW-1:0] rd_s2; // Synchronised read data, stage 2
  logic [DW-1:0] rd_s3; // Synchronised read data, stage 3
  logic take; // Request accepted this cycle

  // Read data pins cross into the host clock
  rdata_sync #(.W(DW)) u_rdata_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .pin(RDATA_OUT),
    .stage2(rd_s2),
    .stage3(rd_s3)
  );

  assign take = REQ_VALID && ready_reg && (state_reg == ST_IDLE);

  // Sequencer: next state and pin values
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    is_wr_next = is_wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    sel_n_next = sel_n_reg;
    wen_n_next = wen_n_reg;
    ready_next = ready_reg;
    rsp_v_next = 1'b0;
    rsp_d_next = rsp_d_reg;
    case (state_reg)
      // Wait for a request; address is presented while select is high
      ST_IDLE: begin
        if (take) begin
          addr_next = REQ_ADDR;
          wdata_next = REQ_WDATA;
          is_wr_next = REQ_WRITE;
          ready_next = 1'b0;
          state_next = ST_SETUP;
        end
      end
      // Address has settled; open the access
      ST_SETUP: begin
        sel_n_next = 1'b0;
        wen_n_next = !is_wr_reg;
        cnt_next = 8'h00;
        state_next = is_wr_reg ? ST_WPULSE : ST_ACCESS;
      end
      // Read: wait access time plus sync, then take a settled word
      ST_ACCESS: begin
        if (cnt_reg < ACC_WAIT) begin
          cnt_next = cnt_reg + 8'h01;
        end else if (rd_s2 == rd_s3) begin
          rsp_d_next = rd_s3;
          rsp_v_next = 1'b1;
          sel_n_next = 1'b1;
          state_next = ST_RFINISH;
        end
      end
      // Read closed; address held one more cycle
      ST_RFINISH: begin
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      // Write strobe low for pulse, data and address lead times
      ST_WPULSE: begin
        if (cnt_reg < WLOW_WAIT - 8'h01) begin
          cnt_next = cnt_reg + 8'h01;
        end else begin
          wen_n_next = 1'b1;
          sel_n_next = 1'b1;
          state_next = ST_WFINISH;
        end
      end
      // Recovery: address and data held past the end of write
      ST_WFINISH: begin
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        sel_n_next = 1'b1;
        wen_n_next = 1'b1;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      is_wr_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      sel_n_reg <= SEL_N_RESET;
      wen_n_reg <= WEN_N_RESET;
      ready_reg <= 1'b1;
      rsp_v_reg <= 1'b0;
      rsp_d_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      is_wr_reg <= is_wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      sel_n_reg <= sel_n_next;
      wen_n_reg <= wen_n_next;
      ready_reg <= ready_next;
      rsp_v_reg <= rsp_v_next;
      rsp_d_reg <= rsp_d_next;
    end
  end

  // Outputs come straight from flip-flops
  assign REQ_READY = ready_reg;
  assign RSP_VALID = rsp_v_reg;
  assign RSP_RDATA = rsp_d_reg;
  assign ADDR_IN = addr_reg;
  assign WDATA_IN = wdata_reg;
  assign SEL_N = sel_n_reg;
  assign WEN_N = wen_n_reg;

  // Helper logic for checks: age of address and data, strobe low time
  logic [AW-1:0] a_prev_reg, a_prev_next; // Address one cycle ago
  logic [DW-1:0] d_prev_reg, d_prev_next; // Data one cycle ago
  logic [7:0] a_age_reg, a_age_next; // Cycles the address has stood
  logic [7:0] d_age_reg, d_age_next; // Cycles the data has stood
  logic [7:0] wlow_reg, wlow_next; // Cycles write-enable has been low

  // Next values of the helper counts
  always_comb begin
    a_prev_next = ADDR_IN;
    d_prev_next = WDATA_IN;
    a_age_next = (ADDR_IN != a_prev_reg) ? 8'h01 : ((a_age_reg == CNT_MAX) ? CNT_MAX : a_age_reg + 8'h01);
    d_age_next = (WDATA_IN != d_prev_reg) ? 8'h01 : ((d_age_reg == CNT_MAX) ? CNT_MAX : d_age_reg + 8'h01);
    wlow_next = WEN_N ? 8'h00 : ((wlow_reg == CNT_MAX) ? CNT_MAX : wlow_reg + 8'h01);
  end

  // Helper registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_prev_reg <= '0;
      d_prev_reg <= '0;
      a_age_reg <= CNT_MAX;
      d_age_reg <= CNT_MAX;
      wlow_reg <= 8'h00;
    end else begin
      a_prev_reg <= a_prev_next;
      d_prev_reg <= d_prev_next;
      a_age_reg <= a_age_next;
      d_age_reg <= d_age_next;
      wlow_reg <= wlow_next;
    end
  end

  localparam logic [7:0] RD_CYC_MIN = 8'(READ_CYCLE_CYC);
  localparam logic [7:0] WR_CYC_MIN = 8'(WRITE_CYCLE_CYC);
  localparam logic [7:0] AVW_MIN = 8'(ADDR_TO_WEND_CYC);
  localparam logic [7:0] DVW_MIN = 8'(DATA_TO_WEND_CYC);
  localparam logic [7:0] WP_MIN = 8'(WRITE_PULSE_CYC);

  // Steps of an access
  sequence s_rd_accept;
    take && !REQ_WRITE;
  endsequence
  sequence s_wr_end;
    $rose(WEN_N);
  endsequence
  sequence s_addr_change;
    ADDR_IN != a_prev_reg;
  endsequence

  a_read_wen_high: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (!SEL_N && !is_wr_reg) |-> WEN_N) else $error("write enable low during a read");

  a_write_overlap: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !WEN_N |-> !SEL_N) else $error("write enable low without select");

  a_write_end_both: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $rose(SEL_N) |-> WEN_N) else $error("select rose while write enable still low");

  a_addr_before_sel: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $fell(SEL_N) |-> (ADDR_IN == a_prev_reg)) else $error("address moved as select fell");

  a_read_answer: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_rd_accept |-> ##[5:40] RSP_VALID) else $error("read answer out of window");

  a_cycle_length: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_addr_change |-> (a_age_reg >= (is_wr_reg ? WR_CYC_MIN : RD_CYC_MIN))) else $error("access cycle too short");

  a_addr_to_wend: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_wr_end |-> (a_age_reg >= AVW_MIN)) else $error("address not stable before write end");

  a_data_to_wend: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_wr_end |-> (d_age_reg >= DVW_MIN) && (wlow_reg >= WP_MIN)) else $error("write data or pulse too short");

  a_hold_after_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_wr_end |=> (ADDR_IN == $past(ADDR_IN)) && (WDATA_IN == $past(WDATA_IN))) else $error("no hold after write end");

endmodule

/* verilog/sram_host_pkg.sv */
package sram_host_pkg;

  // Memory organisation
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;
  localparam int WORD_COUNT = 1048576;

  // Host clock period
  localparam int CLK_PERIOD_NS = 8;

  // Device timing, slow grade figures so both grades are served
  localparam int ACCESS_NS = 15;
  localparam int READ_CYCLE_NS = 15;
  localparam int WRITE_CYCLE_NS = 15;
  localparam int ADDR_TO_WEND_NS = 10;
  localparam int WRITE_PULSE_NS = 9;
  localparam int DATA_TO_WEND_NS = 9;
  localparam int ADDR_SETUP_NS = 1;
  localparam int WRITE_RECOVERY_NS = 1;

  // Least time in whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Cycle counts derived from the times above
  localparam int ACCESS_CYC = min_cycles(ACCESS_NS);
  localparam int READ_CYCLE_CYC = min_cycles(READ_CYCLE_NS);
  localparam int WRITE_CYCLE_CYC = min_cycles(WRITE_CYCLE_NS);
  localparam int ADDR_TO_WEND_CYC = min_cycles(ADDR_TO_WEND_NS);
  localparam int WRITE_PULSE_CYC = min_cycles(WRITE_PULSE_NS);
  localparam int DATA_TO_WEND_CYC = min_cycles(DATA_TO_WEND_NS);
  localparam int ADDR_SETUP_CYC = min_cycles(ADDR_SETUP_NS);
  localparam int WRITE_RECOVERY_CYC = min_cycles(WRITE_RECOVERY_NS);

  // Low time of the write strobe covers every lead-in to its end
  localparam int WRITE_LOW_CYC = max2(WRITE_PULSE_CYC, max2(DATA_TO_WEND_CYC, ADDR_TO_WEND_CYC));

  // Extra wait for the read data synchroniser
  localparam int SYNC_CYC = 3;

  // Reset levels of the pin outputs
  localparam logic SEL_N_RESET = 1'b1;
  localparam logic WEN_N_RESET = 1'b1;

  // Controller states, Gray along read and write paths
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACCESS = 3'b011,
    ST_RFINISH = 3'b010,
    ST_WPULSE = 3'b101,
    ST_WFINISH = 3'b100
  } state_t;

endpackage
